// *** hw/osc_pkg.sv ***
/*
 * Constants and carrier types for the oscillator trim and clock source block.
 * Assumes a 50 MHz system clock and an AXI4-Lite register master.
 */
package osc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] main_osc_trim_off    = 12'h034;
  localparam logic [11:0] osc_gain_setting_off = 12'h038;
  localparam logic [11:0] lp_osc_trim_off      = 12'h03c;
  localparam logic [11:0] lp_osc_ctrl_off      = 12'h040;
  localparam logic [11:0] table_select_off     = 12'h044;
  localparam logic [11:0] table_cmd_off        = 12'h048;
  localparam logic [11:0] table_data_lo_off    = 12'h04c;
  localparam logic [11:0] table_data_hi_off    = 12'h050;
  localparam logic [11:0] irq_status_off       = 12'h054;
  localparam logic [11:0] irq_mask_off         = 12'h058;
  localparam logic [11:0] table_status_off     = 12'h05c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int lp_ctrl_normal_bit  = 0;
  localparam int lp_ctrl_itmr_bit    = 1;
  localparam int lp_ctrl_tcap_bit    = 2;
  localparam int irq_wake_bit        = 0;
  localparam int irq_table_done_bit  = 1;
  localparam int irq_bad_key_bit     = 2;

  // ----------------------------------------------------------------
  // Reset values and service-call constants
  // ----------------------------------------------------------------
  localparam logic [7:0] main_trim_reset   = 8'h80;
  localparam logic [7:0] gain_reset        = 8'h40;
  localparam logic [7:0] lp_trim_reset     = 8'h80;
  localparam logic [2:0] lp_ctrl_reset     = 3'h0;
  localparam logic [7:0] supervisory_key   = 8'h3a;
  localparam logic [7:0] table_read_opcode = 8'h06;
  localparam logic [2:0] irq_mask_reset    = 3'h0;
  localparam logic [2:0] trim_table_main   = 3'h2;
  localparam logic [2:0] trim_table_lp     = 3'h3;
  localparam logic [2:0] silicon_table     = 3'h0;
  localparam logic [1:0] axi_okay          = 2'h0;
  localparam logic [1:0] axi_slverr        = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int sys_clk_hz     = 50_000_000;
  localparam int main_osc_hz    = 24_000_000;
  localparam int lp_osc_hz      = 32_000;
  localparam int main_div_count = sys_clk_hz / main_osc_hz;
  localparam int lp_div_count   = sys_clk_hz / lp_osc_hz;
  localparam int wake_lp_ticks  = 512;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] main_trim;
    logic [7:0] gain;
    logic [7:0] lp_trim;
    logic       lp_normal;
  } osc_cfg_type;

  typedef struct packed {
    logic itmr_lp;
    logic tcap_lp;
  } clk_sel_type;

endpackage

// *** hw/osc_tick.sv ***
/*
 * Accumulating divider that makes a one-cycle enable pulse at a nominal rate.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module osc_tick
  import osc_pkg::*;
#(
  parameter int div_count = 2
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic [7:0] trim,
  output logic            tick
);

  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic        tick_nxt;
  logic [23:0] limit;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Trim nudges the period around its nominal length of div_count cycles;
  // clamped so a low trim cannot wrap the limit and stall the tick
  always_comb begin
    if (24'(div_count) + 24'(trim[7:4]) > 24'd9) begin
      limit = 24'(div_count) + 24'(trim[7:4]) - 24'd9;
    end else begin
      limit = 24'd0;
    end
    cnt_nxt  = cnt_r + 24'd1;
    tick_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = 24'd0;
    end else if (cnt_r >= limit) begin
      cnt_nxt  = 24'd0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 24'd0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

// *** hw/osc_ctrl.sv ***
/*
 * Oscillator trim, gain and clock source control with a table-read service.
 * Assumes an AXI4-Lite master on aclk; suspend_req is a same-clock level.
 */
// Summary of operation
// - Two oscillator enables: trimmable 24 MHz main and 32 kHz low power
// - Low-power tick keeps running in suspend and times periodic wakeup
// - Low-power tick selectable for interval and capture timer clocks
// - Low-power oscillator has low-power and normal accurate settings
// - Trim registers load 3.30V values at power on
// - Main trim at 0x34 writable, sets the 24 MHz trim
// - Gain register at 0x38 writable alongside the trim
// - Table 2 holds main trims at FCh..FFh, 3.30V first
// - Table 3 holds low-power trims at F8h..FBh, 3.30V first
// - Table 0 returns silicon id, upper byte F8, lower F9
// - After table 2 read, main trims sit at FC..FF
// - Table read uses three low bits; copies eight bytes F8h..FFh
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl
  import osc_pkg::*;
#(
  parameter logic [15:0] silicon_id = 16'h1234,
  parameter int          lp_div     = lp_div_count,
  parameter int          wake_ticks = wake_lp_ticks
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        suspend_req,
  output osc_cfg_type      osc_cfg,
  output logic             main_osc_tick,
  output logic             lp_osc_tick,
  output logic             interval_timer_clock,
  output logic             capture_timer_clock,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Trim tables; rows 2 and 3 hold per-voltage trims
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_copy = 2'b01,
    st_done = 2'b10
  } tbl_state_type;

  logic [7:0] rom [0:7][0:7];
  generate
    for (genvar t = 0; t < 8; t++) begin : g_tbl
      for (genvar b = 0; b < 8; b++) begin : g_byte
        if (t == 0 && b == 0) begin : g_id_hi
          assign rom[t][b] = silicon_id[15:8];
        end else if (t == 0 && b == 1) begin : g_id_lo
          assign rom[t][b] = silicon_id[7:0];
        end else if (t == 2 && b >= 4) begin : g_main
          assign rom[t][b] = main_trim_reset + 8'(b - 4);
        end else if (t == 3 && b < 4) begin : g_lp
          assign rom[t][b] = lp_trim_reset + 8'(b);
        end else begin : g_blank
          assign rom[t][b] = 8'h00;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]    main_trim_r, main_trim_nxt;
  logic [7:0]    gain_r, gain_nxt;
  logic [7:0]    lp_trim_r, lp_trim_nxt;
  logic [2:0]    lp_ctrl_r, lp_ctrl_nxt;
  logic [7:0]    sel_r, sel_nxt;
  logic [7:0]    key_r, key_nxt;
  logic [7:0]    frame_r, frame_nxt;
  logic [7:0]    sram_r [0:7];
  logic [7:0]    sram_nxt [0:7];
  logic [2:0]    idx_r, idx_nxt;
  tbl_state_type st_r, st_nxt;
  logic [2:0]    stat_r, stat_nxt;
  logic [2:0]    mask_r, mask_nxt;
  logic [15:0]   wake_cnt_r, wake_cnt_nxt;
  logic          aw_ok_r, aw_ok_nxt;
  logic          w_ok_r, w_ok_nxt;
  logic [11:0]   awaddr_r, awaddr_nxt;
  logic [31:0]   wdata_r, wdata_nxt;
  logic          bvalid_nxt, rvalid_nxt;
  logic [1:0]    bresp_nxt, rresp_nxt;
  logic [31:0]   rdata_nxt;
  logic          irq_nxt;
  logic          main_tick, lp_tick;
  logic          wr_fire, rd_fire;
  logic [2:0]    ev;

  // ----------------------------------------------------------------
  // Oscillator dividers
  // ----------------------------------------------------------------
  // Main oscillator stops in suspend; the low-power one never does
  osc_tick #(.div_count(main_div_count)) u_main (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (!suspend_req),
    .trim    (main_trim_r),
    .tick    (main_tick)
  );

  osc_tick #(.div_count(lp_div)) u_lp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (1'b1),
    .trim    (lp_ctrl_r[lp_ctrl_normal_bit] ? lp_trim_r : lp_trim_reset),
    .tick    (lp_tick)
  );

  assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    main_trim_nxt = main_trim_r;
    gain_nxt      = gain_r;
    lp_trim_nxt   = lp_trim_r;
    lp_ctrl_nxt   = lp_ctrl_r;
    sel_nxt       = sel_r;
    key_nxt       = key_r;
    frame_nxt     = frame_r;
    idx_nxt       = idx_r;
    st_nxt        = st_r;
    mask_nxt      = mask_r;
    aw_ok_nxt     = aw_ok_r;
    w_ok_nxt      = w_ok_r;
    awaddr_nxt    = awaddr_r;
    wdata_nxt     = wdata_r;
    bvalid_nxt    = s_axi_bvalid;
    bresp_nxt     = s_axi_bresp;
    rvalid_nxt    = s_axi_rvalid;
    rresp_nxt     = s_axi_rresp;
    rdata_nxt     = s_axi_rdata;
    ev            = 3'h0;
    wake_cnt_nxt  = wake_cnt_r;
    for (int i = 0; i < 8; i++) begin
      sram_nxt[i] = sram_r[i];
    end
    // Periodic wakeup counted on low-power ticks
    if (lp_tick) begin
      if (wake_cnt_r >= 16'(wake_ticks - 1)) begin
        wake_cnt_nxt     = 16'd0;
        ev[irq_wake_bit] = 1'b1;
      end else begin
        wake_cnt_nxt = wake_cnt_r + 16'd1;
      end
    end
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_nxt  = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_nxt  = 1'b1;
      wdata_nxt = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_ok_nxt  = 1'b0;
      w_ok_nxt   = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = axi_okay;
      case (awaddr_r)
        main_osc_trim_off:    main_trim_nxt = wdata_r[7:0];
        osc_gain_setting_off: gain_nxt = wdata_r[7:0];
        lp_osc_trim_off:      lp_trim_nxt = wdata_r[7:0];
        lp_osc_ctrl_off:      lp_ctrl_nxt = wdata_r[2:0];
        table_select_off:     sel_nxt = wdata_r[7:0];
        table_cmd_off: begin
          // Key, stack frame and opcode arrive in one word
          key_nxt   = wdata_r[7:0];
          frame_nxt = wdata_r[15:8];
          if (st_r == st_idle && wdata_r[7:0] == supervisory_key
              && wdata_r[23:16] == table_read_opcode) begin
            st_nxt  = st_copy;
            idx_nxt = 3'd0;
          end else begin
            ev[irq_bad_key_bit] = 1'b1;
          end
        end
        irq_mask_off:         mask_nxt = wdata_r[2:0];
        default:              bresp_nxt = axi_slverr;
      endcase
    end
    // Table copy: one byte per cycle into the parameter area
    case (st_r)
      st_idle: begin
      end
      st_copy: begin
        sram_nxt[idx_r] = rom[sel_r[2:0]][idx_r];
        idx_nxt         = idx_r + 3'd1;
        if (idx_r == 3'd7) begin
          st_nxt = st_done;
        end
      end
      st_done: begin
        ev[irq_table_done_bit] = 1'b1;
        st_nxt                 = st_idle;
      end
      default: st_nxt = st_idle;
    endcase
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = axi_okay;
      rdata_nxt  = 32'h0;
      case (s_axi_araddr)
        main_osc_trim_off:    rdata_nxt = {24'h0, main_trim_r};
        osc_gain_setting_off: rdata_nxt = {24'h0, gain_r};
        lp_osc_trim_off:      rdata_nxt = {24'h0, lp_trim_r};
        lp_osc_ctrl_off:      rdata_nxt = {29'h0, lp_ctrl_r};
        table_select_off:     rdata_nxt = {24'h0, sel_r};
        table_cmd_off:        rdata_nxt = {16'h0, frame_r, key_r};
        table_data_lo_off:    rdata_nxt = {sram_r[3], sram_r[2], sram_r[1], sram_r[0]};
        table_data_hi_off:    rdata_nxt = {sram_r[7], sram_r[6], sram_r[5], sram_r[4]};
        irq_status_off:       rdata_nxt = {29'h0, stat_r};
        irq_mask_off:         rdata_nxt = {29'h0, mask_r};
        table_status_off:     rdata_nxt = {31'h0, st_r != st_idle};
        default:              rresp_nxt = axi_slverr;
      endcase
    end
    // Read clears status; a same-cycle event still sets
    stat_nxt = stat_r;
    if (rd_fire && s_axi_araddr == irq_status_off) begin
      stat_nxt = 3'h0;
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_trim_r   <= main_trim_reset;
      gain_r        <= gain_reset;
      lp_trim_r     <= lp_trim_reset;
      lp_ctrl_r     <= lp_ctrl_reset;
      sel_r         <= 8'h00;
      key_r         <= 8'h00;
      frame_r       <= 8'h00;
      idx_r         <= 3'd0;
      st_r          <= st_idle;
      stat_r        <= 3'h0;
      mask_r        <= irq_mask_reset;
      wake_cnt_r    <= 16'd0;
      aw_ok_r       <= 1'b0;
      w_ok_r        <= 1'b0;
      awaddr_r      <= 12'h0;
      wdata_r       <= 32'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= axi_okay;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= axi_okay;
      s_axi_rdata   <= 32'h0;
      irq           <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        sram_r[i] <= 8'h00;
      end
    end else begin
      main_trim_r   <= main_trim_nxt;
      gain_r        <= gain_nxt;
      lp_trim_r     <= lp_trim_nxt;
      lp_ctrl_r     <= lp_ctrl_nxt;
      sel_r         <= sel_nxt;
      key_r         <= key_nxt;
      frame_r       <= frame_nxt;
      idx_r         <= idx_nxt;
      st_r          <= st_nxt;
      stat_r        <= stat_nxt;
      mask_r        <= mask_nxt;
      wake_cnt_r    <= wake_cnt_nxt;
      aw_ok_r       <= aw_ok_nxt;
      w_ok_r        <= w_ok_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
      irq           <= irq_nxt;
      for (int i = 0; i < 8; i++) begin
        sram_r[i] <= sram_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready flags and clock outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_arready        <= 1'b0;
      osc_cfg              <= '0;
      main_osc_tick        <= 1'b0;
      lp_osc_tick          <= 1'b0;
      interval_timer_clock <= 1'b0;
      capture_timer_clock  <= 1'b0;
    end else begin
      // One beat each; held low until the response is taken
      s_axi_awready <= !aw_ok_nxt && !bvalid_nxt && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_ok_nxt && !bvalid_nxt && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rvalid_nxt && !rd_fire;
      osc_cfg       <= '{main_trim_r, gain_r, lp_trim_r, lp_ctrl_r[lp_ctrl_normal_bit]};
      main_osc_tick <= main_tick;
      lp_osc_tick   <= lp_tick;
      interval_timer_clock <= lp_ctrl_r[lp_ctrl_itmr_bit] ? lp_tick : main_tick;
      capture_timer_clock  <= lp_ctrl_r[lp_ctrl_tcap_bit] ? lp_tick : main_tick;
    end
  end

endmodule
`default_nettype wire

// *** testbench/osc_ctrl_sva.sv ***
/*
 * Port-level checker for the oscillator control block.
 * Assumes one clock aclk and synchronous active-low aresetn.
 */
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_sva
  import osc_pkg::*;
#(
  parameter int lp_div     = 8,
  parameter int wake_ticks = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        suspend_req,
  input wire osc_cfg_type osc_cfg,
  input wire logic        main_osc_tick,
  input wire logic        lp_osc_tick,
  input wire logic        interval_timer_clock,
  input wire logic        capture_timer_clock,
  input wire logic        irq
);
  // ----------------------------------------
  // Gap since last slow tick
  // ----------------------------------------
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  logic        aw_hs;
  assign aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Restart on every slow tick, so a stalled divider shows as a long gap
  always_comb begin
    gap_nxt = lp_osc_tick ? 16'h0000 : gap_r + 16'h0001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_b_latency: assert property (aw_hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_main_trim_act: assert property (aw_hs && s_axi_awaddr == main_osc_trim_off |->
    ##3 osc_cfg.main_trim == $past(s_axi_wdata[7:0], 3))
    else $error("main trim not applied");
  chk_gain_act: assert property (aw_hs && s_axi_awaddr == osc_gain_setting_off |->
    ##3 osc_cfg.gain == $past(s_axi_wdata[7:0], 3))
    else $error("gain not applied");
  chk_trim_reset: assert property ($rose(aresetn) |-> ##[1:2]
    osc_cfg.main_trim == main_trim_reset && osc_cfg.lp_trim == lp_trim_reset)
    else $error("trim reset value wrong");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("outputs active in reset");
  chk_suspend_main: assert property (suspend_req [*3] |-> !main_osc_tick)
    else $error("main tick in suspend");
  chk_lp_running: assert property (gap_r < 16'(4 * lp_div + 4))
    else $error("slow tick stopped");
  chk_lp_pulse: assert property (lp_osc_tick |=> !lp_osc_tick)
    else $error("slow tick too long");
  chk_itmr_source: assert property (suspend_req [*4] ##0 interval_timer_clock |->
    lp_osc_tick || $past(lp_osc_tick)) else $error("interval clock not slow");
  chk_tcap_source: assert property (suspend_req [*4] ##0 capture_timer_clock |->
    lp_osc_tick || $past(lp_osc_tick)) else $error("capture clock not slow");
endmodule
bind osc_ctrl osc_ctrl_sva #(.lp_div(lp_div), .wake_ticks(wake_ticks)) u_sva (.*);
`default_nettype wire

// *** testbench/osc_ctrl_tb.sv ***
/*
 * Self-checking bench for the oscillator control block.
 * Assumes the checker is bound from its own file; no external model.
 */
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_tb;
  import osc_pkg::*;
  localparam logic [15:0] sid = 16'h1234; // Arbitrary identifier value
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, suspend_req, main_osc_tick, lp_osc_tick, irq;
  logic interval_timer_clock, capture_timer_clock;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] rd;
  osc_cfg_type osc_cfg;
  int          err_count;
  int          n_compared;

  osc_ctrl #(.silicon_id(sid), .lp_div(8), .wake_ticks(4)) u_dut (.*);

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Requests held until taken; answers read at the edge that takes them
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b   = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [11:0] a);
    logic r;
    r = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      r   = s_axi_rvalid && s_axi_rready;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge aclk);
  endtask

  task automatic table_read(input logic [7:0] sel);
    int i;
    axi_write(table_select_off, {24'h0, sel});
    axi_write(table_cmd_off, {8'h0, table_read_opcode, 8'h05, supervisory_key});
    rd = 32'h1;
    for (i = 0; i < 50 && rd[0] !== 1'b0; i++) axi_read(table_status_off);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    axi_read(main_osc_trim_off);
    cmp("main trim reset", {24'h0, main_trim_reset}, rd);
    axi_read(osc_gain_setting_off);
    cmp("gain reset", {24'h0, gain_reset}, rd);
    axi_read(lp_osc_trim_off);
    cmp("lp trim reset", {24'h0, lp_trim_reset}, rd);
    // Main tick at its nominal rate with the reset trim
    repeat (12) begin
      @(posedge aclk);
      if (main_osc_tick === 1'b1) n++;
    end
    cmp("main ticks", 32'(12 / main_div_count), 32'(n));
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [7:0] gv [2] = '{8'h40, 8'hff};
    foreach (gv[i]) begin
      axi_write(osc_gain_setting_off, {24'h0, gv[i]});
      axi_write(main_osc_trim_off, {24'h0, gv[i] ^ 8'h5a});
      axi_read(osc_gain_setting_off);
      cmp("gain", {24'h0, gv[i]}, rd);
      axi_read(main_osc_trim_off);
      cmp("main trim", {24'h0, gv[i] ^ 8'h5a}, rd);
      cmp("cfg main trim", {24'h0, gv[i] ^ 8'h5a}, {24'h0, osc_cfg.main_trim});
    end
    axi_write(lp_osc_trim_off, 32'h0000_007e);
    axi_read(lp_osc_trim_off);
    cmp("lp trim", 32'h7e, rd);
    axi_write(12'h100, 32'h0000_00aa);
    cmp("unmapped write resp", {30'h0, axi_slverr}, {30'h0, rsp});
    axi_read(12'h100);
    cmp("unmapped read resp", {30'h0, axi_slverr}, {30'h0, rsp});
    $display("test registers done");
  endtask

  task automatic t_tables();
    table_read(8'h00);
    axi_read(table_data_lo_off);
    cmp("silicon id", {16'h0, sid[7:0], sid[15:8]}, {16'h0, rd[15:0]});
    table_read(8'h02);
    axi_read(table_data_hi_off);
    cmp("main trim table", 32'h8382_8180, rd);
    table_read(8'h0b);
    axi_read(table_data_lo_off);
    cmp("lp trim table", 32'h8382_8180, rd);
    axi_read(irq_status_off);
    cmp("done status", 32'h2, {30'h0, rd[irq_table_done_bit], 1'b0});
    $display("test tables done");
  endtask

  task automatic t_irq();
    axi_write(irq_mask_off, 32'h0);
    axi_write(table_cmd_off, 32'h0006_0500);
    cmp("bad key resp", {30'h0, axi_okay}, {30'h0, rsp});
    repeat (5) @(posedge aclk);
    cmp("masked irq", 32'h0, {31'h0, irq});
    axi_write(irq_mask_off, 32'h4);
    wait_irq(20);
    cmp("unmasked irq", 32'h1, {31'h0, irq});
    axi_read(irq_status_off);
    cmp("bad key status", 32'h4, rd & 32'h4);
    repeat (3) @(posedge aclk);
    cmp("irq after clear", 32'h0, {31'h0, irq});
    $display("test interrupt done");
  endtask

  task automatic t_suspend();
    int   n;
    logic woke;
    n    = 0;
    woke = 1'b0;
    axi_write(lp_osc_ctrl_off, 32'h7);
    suspend_req <= 1'b1;
    axi_write(irq_mask_off, 32'h1);
    // Stale wake bits cleared, so only a wake during suspend counts
    axi_read(irq_status_off);
    repeat (80) begin
      @(posedge aclk);
      if (interval_timer_clock === 1'b1 && capture_timer_clock === 1'b1) n++;
      if (irq === 1'b1) woke = 1'b1;
    end
    cmp("wake irq", 32'h1, {31'h0, woke});
    cmp("slow timer clocks", 32'h1, {31'h0, n > 0});
    suspend_req <= 1'b0;
    axi_write(irq_mask_off, 32'h0);
    axi_read(irq_status_off);
    cmp("wake status", 32'h1, rd & 32'h1);
    $display("test suspend done");
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, suspend_req, s_axi_awaddr, s_axi_araddr} = 26'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_regs();
    t_tables();
    t_irq();
    t_suspend();
    complete_run();
  end

  // Whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
